// File: rtl/pgc_defs.svh
// constants for the pwm generator control block
// assumes a 32-bit ahb-lite register bus, one word per register
`ifndef PGC_DEFS_SVH
`define PGC_DEFS_SVH
// register byte offsets
`define PGC_OFF_CTRL    8'h00
`define PGC_OFF_GDUTY   8'h04
`define PGC_OFF_MDUTY   8'h08
`define PGC_OFF_PHASE   8'h0C
`define PGC_OFF_PPER    8'h10
`define PGC_OFF_DT      8'h14
`define PGC_OFF_ALTDT   8'h18
`define PGC_OFF_STAT    8'h1C
// generator control field positions
`define PGC_B_FLTPEND   15
`define PGC_B_CLPEND    14
`define PGC_B_TRGPEND   13
`define PGC_B_FAULT_IRQ_ENABLE    12
`define PGC_B_CURRENT_LIMIT_IRQ_ENABLE     11
`define PGC_B_TRIGGER_IRQ_ENABLE    10
`define PGC_B_ITB       9
`define PGC_B_MASTER_DUTY_SELECT      8
`define PGC_B_DTC_HI    7
`define PGC_B_DTC_LO    6
`define PGC_B_COMPENSATION_POLARITY      5
`define PGC_B_MASTER_BASE_SELECT      3
`define PGC_B_CAM       2
`define PGC_B_EXTERNAL_PERIOD_RESET     1
`define PGC_B_IUE       0
// dead-time modes
`define PGC_DT_POS      2'h0
`define PGC_DT_NEG      2'h1
`define PGC_DT_OFF      2'h2
`define PGC_DT_COMP     2'h3
// widths and reset values
`define PGC_DTW         14
`define PGC_ZERO16      16'h0000
`define PGC_ZERO14      14'h0000
`define PGC_PPER_RST    16'hFFF8
`define PGC_HTRANS_NSEQ 2'h2
`define PGC_AW          8
`endif

// File: rtl/pgc_pkg.sv
// types for the pwm generator control block
// assumes pgc_defs.svh supplies the numeric constants
package pgc_pkg;
    typedef logic [1:0] pgc_dt_t;
    typedef enum logic [1:0] {
        PGC_UP   = 2'b01,
        PGC_DOWN = 2'b10
    } pgc_dir_e;
endpackage

// File: rtl/pgc_top.sv
// pwm generator control: control/duty registers, time base, outputs
// assumes one ahb-lite master, synchronous event inputs on clk_sys
// Notes on behaviour
// - fault pending cleared by writing enable zero
// - current-limit pending cleared by enable zero
// - trigger event raises request, sets pending
// - independent bit picks own period register
// - master duty select picks shared duty
// - two-bit field selects dead-time behaviour
// - polarity honoured only in compensation mode
// - polarity one: input low shortens low
// - polarity zero: input low shortens high
// - base select picks secondary master time base when secondary present
// - center select gives up/down counting
// - center select ignored without independent base
// - current-limit resets independent time base
// - immediate bit or period boundary updates
// - generator duty 16-bit, resets zero
// - control bit 4 reads zero
// - shared master duty 16-bit register
`include "pgc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module pgc_top (
    input  wire logic           clk_sys,
    input  wire logic           reset_n,
    input  wire logic           hsel,
    input  wire logic [31:0]    haddr,
    input  wire logic [1:0]     htrans,
    input  wire logic           hwrite,
    input  wire logic [2:0]     hsize,
    input  wire logic [31:0]    hwdata,
    input  wire logic           hready,
    output var  logic [31:0]    hrdata,
    output var  logic           hreadyout,
    output var  logic           hresp,
    input  wire logic           fault_event,
    input  wire logic           current_limit_event,
    input  wire logic           trigger_event,
    input  wire logic           primary_tick,
    input  wire logic           primary_sync,
    input  wire logic           secondary_tick,
    input  wire logic           secondary_sync,
    input  wire logic           secondary_present,
    input  wire logic           compensation_input,
    output var  logic           fault_irq_req,
    output var  logic           current_limit_irq_req,
    output var  logic           trigger_irq_req,
    output var  logic           high_side_output,
    output var  logic           low_side_output,
    output var  pgc_pkg::pgc_dt_t dead_time_mode,
    output var  logic           shorten_high,
    output var  logic           shorten_low,
    output var  logic [13:0]    active_dead_time,
    output var  logic [13:0]    active_alt_dead_time,
    output var  logic           period_boundary
);
    import pgc_pkg::*;
    // address match on a word offset
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction
    // shadow copy follows source when updates are allowed
    function automatic logic [15:0] upd(input logic [15:0] cur, input logic [15:0] src, input logic go);
        upd = go ? src : cur;
    endfunction

    // bus phase state
    logic           wr_pend_r, wr_pend_nxt;
    logic [7:0]     wr_addr_r, wr_addr_nxt;
    logic [31:0]    rdata_r, rdata_nxt;
    logic           req;
    logic           wr;
    // software registers
    logic           flt_pend_r, flt_pend_nxt;
    logic           cl_pend_r, cl_pend_nxt;
    logic           trg_pend_r, trg_pend_nxt;
    logic [12:0]    ctrl_r, ctrl_nxt;
    logic [15:0]    gduty_r, gduty_nxt;
    logic [15:0]    mduty_r, mduty_nxt;
    logic [15:0]    phase_r, phase_nxt;
    logic [15:0]    pper_r, pper_nxt;
    logic [13:0]    dt_r, dt_nxt;
    logic [13:0]    altdt_r, altdt_nxt;
    logic [15:0]    ctrl_rd;

    // active copies and time base
    logic [15:0]    a_gduty_r, a_gduty_nxt;
    logic [15:0]    a_mduty_r, a_mduty_nxt;
    logic [15:0]    a_phase_r, a_phase_nxt;
    logic [13:0]    a_dt_r, a_dt_nxt;
    logic [13:0]    a_altdt_r, a_altdt_nxt;
    logic [15:0]    cnt_r, cnt_nxt;
    pgc_dir_e       dir_r, dir_nxt;
    logic           bnd;
    logic           tick;
    logic           sync;
    logic [15:0]    per;
    logic [15:0]    duty;
    logic           center;
    logic           xrst;

    // output flops
    logic           hi_r, hi_nxt;
    logic           irq_f_r, irq_c_r, irq_t_r;
    logic           irq_f_nxt, irq_c_nxt, irq_t_nxt;
    logic           sh_h_r, sh_h_nxt;
    logic           sh_l_r, sh_l_nxt;
    logic           bnd_r;

    // control field views
    logic           fie, cie, tie, independent_period_select, master_duty_select, compensation_polarity, master_base_select, center_aligned_select, external_period_reset, immediate_update;
    logic [1:0]     dead_time_control;
    assign fie   = ctrl_r[`PGC_B_FAULT_IRQ_ENABLE];
    assign cie   = ctrl_r[`PGC_B_CURRENT_LIMIT_IRQ_ENABLE];
    assign tie   = ctrl_r[`PGC_B_TRIGGER_IRQ_ENABLE];
    assign independent_period_select   = ctrl_r[`PGC_B_ITB];
    assign master_duty_select  = ctrl_r[`PGC_B_MASTER_DUTY_SELECT];
    assign dead_time_control   = ctrl_r[`PGC_B_DTC_HI:`PGC_B_DTC_LO];
    assign compensation_polarity  = ctrl_r[`PGC_B_COMPENSATION_POLARITY];
    assign master_base_select  = ctrl_r[`PGC_B_MASTER_BASE_SELECT];
    assign center_aligned_select   = ctrl_r[`PGC_B_CAM];
    assign external_period_reset = ctrl_r[`PGC_B_EXTERNAL_PERIOD_RESET];
    assign immediate_update   = ctrl_r[`PGC_B_IUE];

    // control read image, unimplemented bit 4 forced low
    assign ctrl_rd = {flt_pend_r, cl_pend_r, trg_pend_r, ctrl_r[12:5], 1'b0, ctrl_r[3:0]};

    // ahb-lite slave: zero wait states, always okay
    assign req       = hsel && hready && (htrans == `PGC_HTRANS_NSEQ);
    assign wr        = wr_pend_r;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_r;

    always_comb begin
        wr_pend_nxt = req && hwrite;
        wr_addr_nxt = req ? haddr[7:0] : wr_addr_r;
        rdata_nxt   = 32'h0000_0000;
        if (req && !hwrite) begin
            if (hit(haddr[7:0], `PGC_OFF_CTRL))  rdata_nxt = {16'h0000, ctrl_rd};
            if (hit(haddr[7:0], `PGC_OFF_GDUTY)) rdata_nxt = {16'h0000, gduty_r};
            if (hit(haddr[7:0], `PGC_OFF_MDUTY)) rdata_nxt = {16'h0000, mduty_r};
            if (hit(haddr[7:0], `PGC_OFF_PHASE)) rdata_nxt = {16'h0000, phase_r};
            if (hit(haddr[7:0], `PGC_OFF_PPER))  rdata_nxt = {16'h0000, pper_r};
            if (hit(haddr[7:0], `PGC_OFF_DT))    rdata_nxt = {18'h00000, dt_r};
            if (hit(haddr[7:0], `PGC_OFF_ALTDT)) rdata_nxt = {18'h00000, altdt_r};
            if (hit(haddr[7:0], `PGC_OFF_STAT))  rdata_nxt = {16'h0000, cnt_r};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rdata_r   <= 32'h0000_0000;
        end else begin
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // register writes and sticky pending flags; a set beats a same-cycle clear
    always_comb begin
        ctrl_nxt  = ctrl_r;
        gduty_nxt = gduty_r;
        mduty_nxt = mduty_r;
        phase_nxt = phase_r;
        pper_nxt  = pper_r;
        dt_nxt    = dt_r;
        altdt_nxt = altdt_r;
        if (wr && hit(wr_addr_r, `PGC_OFF_CTRL)) ctrl_nxt = hwdata[12:0];
        if (wr && hit(wr_addr_r, `PGC_OFF_GDUTY)) gduty_nxt = hwdata[15:0];
        if (wr && hit(wr_addr_r, `PGC_OFF_MDUTY)) mduty_nxt = hwdata[15:0];
        if (wr && hit(wr_addr_r, `PGC_OFF_PHASE)) phase_nxt = hwdata[15:0];
        if (wr && hit(wr_addr_r, `PGC_OFF_PPER)) pper_nxt = hwdata[15:0];
        if (wr && hit(wr_addr_r, `PGC_OFF_DT)) dt_nxt = hwdata[`PGC_DTW-1:0];
        if (wr && hit(wr_addr_r, `PGC_OFF_ALTDT)) altdt_nxt = hwdata[`PGC_DTW-1:0];
        flt_pend_nxt = (fie && fault_event) || (flt_pend_r && ctrl_nxt[`PGC_B_FAULT_IRQ_ENABLE]);
        cl_pend_nxt = (cie && current_limit_event) || (cl_pend_r && ctrl_nxt[`PGC_B_CURRENT_LIMIT_IRQ_ENABLE]);
        trg_pend_nxt = (tie && trigger_event) || (trg_pend_r && ctrl_nxt[`PGC_B_TRIGGER_IRQ_ENABLE]);
        irq_f_nxt = fie && fault_event;
        irq_c_nxt = cie && current_limit_event;
        irq_t_nxt = tie && trigger_event;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            ctrl_r     <= 13'h0000;
            gduty_r    <= `PGC_ZERO16;
            mduty_r    <= `PGC_ZERO16;
            phase_r    <= `PGC_ZERO16;
            pper_r     <= `PGC_PPER_RST;
            dt_r       <= `PGC_ZERO14;
            altdt_r    <= `PGC_ZERO14;
            flt_pend_r <= 1'b0;
            cl_pend_r  <= 1'b0;
            trg_pend_r <= 1'b0;
            irq_f_r    <= 1'b0;
            irq_c_r    <= 1'b0;
            irq_t_r    <= 1'b0;
        end else begin
            ctrl_r     <= ctrl_nxt;
            gduty_r    <= gduty_nxt;
            mduty_r    <= mduty_nxt;
            phase_r    <= phase_nxt;
            pper_r     <= pper_nxt;
            dt_r       <= dt_nxt;
            altdt_r    <= altdt_nxt;
            flt_pend_r <= flt_pend_nxt;
            cl_pend_r  <= cl_pend_nxt;
            trg_pend_r <= trg_pend_nxt;
            irq_f_r    <= irq_f_nxt;
            irq_c_r    <= irq_c_nxt;
            irq_t_r    <= irq_t_nxt;
        end
    end

    // time base source, period, duty and mode selection
    always_comb begin
        tick   = (master_base_select && secondary_present) ? secondary_tick : primary_tick;
        sync   = (master_base_select && secondary_present) ? secondary_sync : primary_sync;
        per    = independent_period_select ? a_phase_r : pper_r;
        duty   = master_duty_select ? a_mduty_r : a_gduty_r;
        center = center_aligned_select && independent_period_select;
        xrst   = external_period_reset && independent_period_select && current_limit_event;
        if (center) begin
            bnd = tick && (dir_r == PGC_DOWN) && (cnt_r == `PGC_ZERO16);
        end else begin
            bnd = tick && (cnt_r >= per);
        end
    end

    // counter: edge-aligned wrap or center-aligned up/down
    always_comb begin
        cnt_nxt = cnt_r;
        dir_nxt = dir_r;
        if (xrst || (!independent_period_select && sync)) begin
            cnt_nxt = `PGC_ZERO16;
            dir_nxt = PGC_UP;
        end else if (tick) begin
            unique case (dir_r)
                PGC_UP: begin
                    if (cnt_r >= per) begin
                        cnt_nxt = center ? cnt_r - 16'h0001 : `PGC_ZERO16;
                        dir_nxt = center ? PGC_DOWN : PGC_UP;
                    end else begin
                        cnt_nxt = cnt_r + 16'h0001;
                    end
                end
                PGC_DOWN: begin
                    if (!center || cnt_r == `PGC_ZERO16) begin
                        cnt_nxt = center ? cnt_r + 16'h0001 : `PGC_ZERO16;
                        dir_nxt = PGC_UP;
                    end else begin
                        cnt_nxt = cnt_r - 16'h0001;
                    end
                end
                default: begin
                    cnt_nxt = `PGC_ZERO16;
                    dir_nxt = PGC_UP;
                end
            endcase
        end
        a_gduty_nxt = upd(a_gduty_r, gduty_r, immediate_update || bnd);
        a_mduty_nxt = upd(a_mduty_r, mduty_r, immediate_update || bnd);
        a_phase_nxt = upd(a_phase_r, phase_r, immediate_update || bnd);
        a_dt_nxt    = immediate_update || bnd ? dt_r : a_dt_r;
        a_altdt_nxt = immediate_update || bnd ? altdt_r : a_altdt_r;
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            cnt_r     <= `PGC_ZERO16;
            dir_r     <= PGC_UP;
            a_gduty_r <= `PGC_ZERO16;
            a_mduty_r <= `PGC_ZERO16;
            a_phase_r <= `PGC_ZERO16;
            a_dt_r    <= `PGC_ZERO14;
            a_altdt_r <= `PGC_ZERO14;
        end else begin
            cnt_r     <= cnt_nxt;
            dir_r     <= dir_nxt;
            a_gduty_r <= a_gduty_nxt;
            a_mduty_r <= a_mduty_nxt;
            a_phase_r <= a_phase_nxt;
            a_dt_r    <= a_dt_nxt;
            a_altdt_r <= a_altdt_nxt;
        end
    end

    // pwm compare and dead-time compensation direction
    always_comb begin
        hi_nxt   = cnt_nxt < duty;
        sh_h_nxt = 1'b0;
        sh_l_nxt = 1'b0;
        if (dead_time_control == `PGC_DT_COMP) begin
            if (compensation_polarity) begin
                sh_l_nxt = !compensation_input;
                sh_h_nxt = compensation_input;
            end else begin
                sh_h_nxt = !compensation_input;
                sh_l_nxt = compensation_input;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            hi_r   <= 1'b0;
            sh_h_r <= 1'b0;
            sh_l_r <= 1'b0;
            bnd_r  <= 1'b0;
        end else begin
            hi_r   <= hi_nxt;
            sh_h_r <= sh_h_nxt;
            sh_l_r <= sh_l_nxt;
            bnd_r  <= bnd;
        end
    end

    // outputs; lengthening is the complement of shortening
    assign high_side_output      = hi_r;
    assign low_side_output       = !hi_r;
    assign dead_time_mode        = dead_time_control;
    assign shorten_high          = sh_h_r;
    assign shorten_low           = sh_l_r;
    assign active_dead_time      = a_dt_r;
    assign active_alt_dead_time  = a_altdt_r;
    assign period_boundary       = bnd_r;
    assign fault_irq_req         = irq_f_r;
    assign current_limit_irq_req = irq_c_r;
    assign trigger_irq_req       = irq_t_r;
endmodule
`default_nettype wire

// File: dv/pgc_checker.sv
// checker: port-level assertions for the pwm generator control block
// assumes the pgc_top port list and the single clk_sys domain
`include "pgc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module pgc_checker (
    input wire logic             clk_sys,
    input wire logic             reset_n,
    input wire logic             hsel,
    input wire logic [31:0]      haddr,
    input wire logic [1:0]       htrans,
    input wire logic             hwrite,
    input wire logic [31:0]      hwdata,
    input wire logic             hready,
    input wire logic             hreadyout,
    input wire logic             hresp,
    input wire logic             fault_event,
    input wire logic             current_limit_event,
    input wire logic             trigger_event,
    input wire logic             compensation_input,
    input wire logic             fault_irq_req,
    input wire logic             current_limit_irq_req,
    input wire logic             trigger_irq_req,
    input wire logic             high_side_output,
    input wire logic             low_side_output,
    input wire pgc_pkg::pgc_dt_t dead_time_mode,
    input wire logic             shorten_high,
    input wire logic             shorten_low
);
    import pgc_pkg::*;
    logic        ctl_wr_r;
    logic        ctl_wr_nxt;
    logic [15:0] ctl_r;
    logic [15:0] ctl_nxt;
    // shadow of the control word as written over the bus
    always_comb begin
        ctl_wr_nxt = hsel && hready && htrans == `PGC_HTRANS_NSEQ && hwrite && haddr[7:0] == `PGC_OFF_CTRL;
        ctl_nxt    = ctl_wr_r ? hwdata[15:0] : ctl_r;
    end
    // registers the shadow, cleared in reset
    always_ff @(posedge clk_sys) begin
        ctl_wr_r <= reset_n ? ctl_wr_nxt : 1'b0;
        ctl_r    <= reset_n ? ctl_nxt : 16'h0000;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence comp_mode_s;
        ctl_r[7:6] == `PGC_DT_COMP;
    endsequence
    chk_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    chk_low_inverse: assert property (low_side_output == !high_side_output)
        else $error("low output not inverse of high");
    chk_flt_req: assert property (fault_event |=> fault_irq_req == $past(ctl_r[12]))
        else $error("fault request does not follow enable");
    chk_cl_req: assert property (current_limit_event |=> current_limit_irq_req == $past(ctl_r[11]))
        else $error("current-limit request does not follow enable");
    chk_trg_req: assert property (trigger_event |=> trigger_irq_req == $past(ctl_r[10]))
        else $error("trigger request does not follow enable");
    chk_req_cause: assert property ((trigger_irq_req || fault_irq_req) |->
        $past(trigger_event) || $past(fault_event)) else $error("request without event");
    chk_mode_field: assert property (dead_time_mode == ctl_r[7:6])
        else $error("dead-time mode differs from field");
    chk_comp_side: assert property (comp_mode_s |=> shorten_high == !shorten_low &&
        shorten_low == ($past(ctl_r[5]) ^ $past(compensation_input))) else $error("wrong side shortened");
    chk_comp_off: assert property ((ctl_r[7:6] != `PGC_DT_COMP) |=> !shorten_high && !shorten_low)
        else $error("shortening outside compensation mode");
endmodule
bind pgc_top pgc_checker pgc_checker_inst (
    .clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp,
    .fault_event, .current_limit_event, .trigger_event, .compensation_input, .fault_irq_req,
    .current_limit_irq_req, .trigger_irq_req, .high_side_output, .low_side_output, .dead_time_mode,
    .shorten_high, .shorten_low
);
`default_nettype wire

// File: dv/pgc_gate_model.sv
// gate driver model: counts high-side on time and shoot-through cycles
// assumes outputs settle before each rising clk_sys edge
`timescale 1ns/1ps
`default_nettype none
module pgc_gate_model (
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        high_side_output,
    input  wire logic        low_side_output,
    output var  logic [31:0] high_cnt,
    output var  logic [31:0] overlap_cnt
);
    logic [31:0] high_nxt;
    logic [31:0] overlap_nxt;
    // next counts: on time for duty, both sides on for shoot-through
    always_comb begin
        high_nxt    = high_cnt + {31'h0, high_side_output === 1'b1};
        overlap_nxt = overlap_cnt + {31'h0, high_side_output === 1'b1 && low_side_output === 1'b1};
    end
    // registers the counts
    always_ff @(posedge clk_sys) begin
        high_cnt    <= reset_n ? high_nxt : 32'h0;
        overlap_cnt <= reset_n ? overlap_nxt : 32'h0;
    end
endmodule
`default_nettype wire

// File: dv/test_pwm_generator_control.sv
// testbench: drives pgc_top over ahb-lite and compares with a register model
// assumes pgc_gate_model on the outputs and a 20 MHz clk_sys
`include "pgc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_pwm_generator_control;
    import pgc_pkg::*;
    logic        clk_sys = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, cin = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, hcnt, ocnt, q, v, s1, dv, mv;
    logic [1:0]  htrans = 2'h0, tk = 2'h0;
    logic [2:0]  evt = 3'h0;
    logic        hreadyout, hresp, fault_irq_req, current_limit_irq_req, trigger_irq_req;
    logic        high_side_output, low_side_output, shorten_high, shorten_low, period_boundary;
    logic [13:0] active_dead_time, active_alt_dead_time;
    pgc_dt_t     dead_time_mode;
    logic [31:0] mdl [8] = '{32'h0, 32'h0, 32'h0, 32'h0, {16'h0000, `PGC_PPER_RST}, 32'h0, 32'h0, 32'h0};
    int          mismatches = 0, comparisons = 0, k;
    pgc_top pgc_top_inst (
        .clk_sys, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .fault_event(evt[2]), .current_limit_event(evt[1]),
        .trigger_event(evt[0]), .primary_tick(tk[0]), .primary_sync(1'b0), .secondary_tick(tk[1]),
        .secondary_sync(1'b0), .secondary_present(1'b1), .compensation_input(cin), .fault_irq_req,
        .current_limit_irq_req, .trigger_irq_req, .high_side_output, .low_side_output, .dead_time_mode,
        .shorten_high, .shorten_low, .active_dead_time, .active_alt_dead_time, .period_boundary
    );
    pgc_gate_model pgc_gate_model_inst (
        .clk_sys, .reset_n, .high_side_output, .low_side_output, .high_cnt(hcnt), .overlap_cnt(ocnt)
    );
    // 50 ns clock
    always #25 clk_sys = ~clk_sys;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus phase: hold until hready is seen high, data taken at that edge
    task automatic beat(output logic [31:0] d);
        logic r;
        do begin
            @(posedge clk_sys);
            r = hreadyout;
            d = hrdata;
        end while (r !== 1'b1);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= `PGC_HTRANS_NSEQ;
        hwrite <= w;
        haddr <= {24'h000000, a};
        beat(q);
        htrans <= 2'h0;
        hwdata <= d;
        beat(q);
    endtask
    // write and update the model; enable zero clears its pending bit
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        if (a == `PGC_OFF_CTRL)
            mdl[0] = (d & 32'h1FEF) | ((((mdl[0] >> 3) & d) & 32'h1C00) << 3);
        else if (a < `PGC_OFF_STAT)
            mdl[a >> 2] = d & ((a == `PGC_OFF_DT || a == `PGC_OFF_ALTDT) ? 32'h3FFF : 32'hFFFF);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
        chk(q, (a < `PGC_OFF_STAT) ? mdl[a >> 2] : 32'h0);
    endtask
    task automatic pulse(input int n);
        evt <= 3'h1 << n;
        @(posedge clk_sys);
        evt <= 3'h0;
        if (mdl[0][10 + n])
            mdl[0][13 + n] = 1'b1;
    endtask
    // high time over four whole periods equals four duties
    task automatic duty(input logic [31:0] c, input logic [1:0] s, input int l, input int e);
        logic [31:0] c0;
        tk <= 2'h0;
        wr(`PGC_OFF_CTRL, c); // mode bits change only with the time base stopped
        tk <= s;
        repeat (3 * l) @(negedge clk_sys);
        c0 = hcnt;
        repeat (4 * l) @(negedge clk_sys);
        chk(hcnt - c0, 32'(4 * e));
        @(posedge clk_sys);
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        results();
    end
    // main sequence
    initial begin
        void'($urandom(8831));
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        for (k = 0; k < 9; k++)
            rd(8'(k * 4)); // reset values, unmapped reads zero
        for (k = 0; k < 7; k++) begin
            // immediate update kept off so active copies stay at reset
            wr(8'(k * 4), $urandom & ((k == 0) ? 32'hFFFF_FFFE : 32'hFFFF_FFFF));
            rd(8'(k * 4));
        end
        for (k = 0; k < 3; k++) begin
            wr(`PGC_OFF_CTRL, 32'h1 << (10 + k));
            pulse(k);
            rd(`PGC_OFF_CTRL);
            wr(`PGC_OFF_CTRL, 32'h0); // software clears here too
            pulse(k);
            rd(`PGC_OFF_CTRL);
        end
        wr(`PGC_OFF_CTRL, 32'h0200);
        v = {18'h0, active_dead_time};
        s1 = $urandom;
        wr(`PGC_OFF_DT, s1);
        wr(`PGC_OFF_ALTDT, ~s1);
        wr(`PGC_OFF_PHASE, 32'h9);
        repeat (3) @(negedge clk_sys);
        chk({18'h0, active_dead_time}, v);
        @(posedge clk_sys);
        tk <= 2'h1;
        for (k = 0; k < 200 && period_boundary !== 1'b1; k++)
            @(negedge clk_sys);
        repeat (2) @(negedge clk_sys);
        chk({18'h0, active_alt_dead_time}, ~s1 & 32'h3FFF);
        @(posedge clk_sys);
        tk <= 2'h0;
        wr(`PGC_OFF_CTRL, 32'h0201);
        s1 = $urandom;
        wr(`PGC_OFF_DT, s1);
        repeat (2) @(negedge clk_sys);
        chk({18'h0, active_dead_time}, s1 & 32'h3FFF);
        @(posedge clk_sys);
        wr(`PGC_OFF_PPER, 32'h5);
        dv = 1 + $urandom % 5;
        mv = 1 + $urandom % 5;
        wr(`PGC_OFF_GDUTY, dv);
        wr(`PGC_OFF_MDUTY, mv);
        duty(32'h0201, 2'h1, 10, dv);
        duty(32'h0301, 2'h1, 10, mv);
        duty(32'h0005, 2'h1, 6, dv);
        duty(32'h0209, 2'h2, 10, dv);
        duty(32'h0205, 2'h1, 18, 2 * dv - 1); // up 0..9, down 8..1: 18 ticks
        wr(`PGC_OFF_PHASE, 32'hFF);
        for (k = 1; k >= 0; k--) begin
            wr(`PGC_OFF_CTRL, 32'h0201 | (k << 1)); // current-limit mode kept zero outside
            tk <= 2'h1;
            repeat (20) @(posedge clk_sys);
            tk <= 2'h0;
            bus(1'b0, `PGC_OFF_STAT, 32'h0);
            s1 = q;
            pulse(1);
            bus(1'b0, `PGC_OFF_STAT, 32'h0);
            chk(q & 32'hFFFF, (k == 1) ? 32'h0 : s1 & 32'hFFFF);
        end
        for (k = 0; k < 8; k++) begin
            cin <= 1'($urandom);
            wr(`PGC_OFF_CTRL, k << 5);
            repeat (2) @(negedge clk_sys);
            chk({30'h0, dead_time_mode}, k >> 1);
            chk({30'h0, shorten_high, shorten_low}, (k >= 6) ? {30'h0, ~(k[0] ^ cin), k[0] ^ cin} : 32'h0);
            @(posedge clk_sys);
        end
        chk(ocnt, 32'h0);
        results();
    end
endmodule
`default_nettype wire
